// File: logic/wdpw_map.vh
// Purpose: Offsets, fields, reset values and counts of the watchdog.
// Assumes: Included by every watchdog design file.
// Notes: Definitions only.
`ifndef WDPW_MAP_VH
`define WDPW_MAP_VH
// Register byte offsets
`define WDPW_ADDR_CON0 8'h00
`define WDPW_ADDR_CON1 8'h04
`define WDPW_ADDR_SR 8'h08
`define WDPW_ADDR_ISR 8'h0C
`define WDPW_ADDR_IMR 8'h10
// Control word 0 fields
`define WDPW_C0_ENDINIT 0
`define WDPW_C0_LOCK 1
`define WDPW_C0_PWF_HI 7
`define WDPW_C0_PWF_LO 2
`define WDPW_C0_PWU_HI 15
`define WDPW_C0_PWU_LO 8
`define WDPW_C0_REL_HI 31
`define WDPW_C0_REL_LO 16
// Control word 1 fields
`define WDPW_C1_DIS 2
`define WDPW_C1_PSEL 3
`define WDPW_C1_PWU_HI 15
`define WDPW_C1_PWU_LO 8
// Fixed password part and reset values
`define WDPW_PW_FIX 6'h2A
`define WDPW_PWU_RST 8'h00
`define WDPW_RELOAD_RST 16'h0000
`define WDPW_FIXED_RELOAD 16'hFFFC
`define WDPW_ENDINIT_RST 1'b0
// Event bits of status and mask
`define WDPW_EV_ACC 0
`define WDPW_EV_OVF 1
`define WDPW_EV_END 2
`define WDPW_EV_PRW 3
`define WDPW_EV_N 4
// Timing counts in system clocks
`define WDPW_DIV_LO 256
`define WDPW_DIV_HI 16384
`define WDPW_GAP_CYC 1024
`define WDPW_RST_CYC 16
// Bus answers
`define WDPW_RESP_OK 2'h0
`define WDPW_RESP_ERR 2'h2
`endif

// File: logic/wdpw_presc.v
// Purpose: Tick divider for the watchdog counter.
// Assumes: One system clock, synchronous active-low reset.
// Notes: Restarts the count when the ratio changes.
`include "wdpw_map.vh"
`default_nettype none
module wdpw_presc #(
  parameter DIV_LO = `WDPW_DIV_LO,
  parameter DIV_HI = `WDPW_DIV_HI
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_sel_hi,
  output reg o_tick
);
  reg [15:0] cnt; // Cycles since last tick
  reg sel_q; // Ratio seen last cycle
  wire [15:0] lim = i_sel_hi ? DIV_HI[15:0] - 16'h0001 : DIV_LO[15:0] - 16'h0001;
  // One-cycle tick every DIV cycles
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt <= 16'h0000;
      sel_q <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      sel_q <= i_sel_hi;
      if (sel_q != i_sel_hi || cnt >= lim) begin
        // Ratio switch restarts so no short tick leaks out
        o_tick <= (sel_q == i_sel_hi);
        cnt <= 16'h0000;
      end else begin
        o_tick <= 1'b0;
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule // wdpw_presc
`default_nettype wire

// File: logic/wdpw_gap.v
// Purpose: Limits the gap between the two access writes.
// Assumes: Start and stop are one-cycle pulses.
// Notes: Expiry is a one-cycle pulse.
`include "wdpw_map.vh"
`default_nettype none
module wdpw_gap #(
  parameter GAP_CYC = `WDPW_GAP_CYC
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_start,
  input wire i_stop,
  output reg o_expire
);
  reg run; // Window open
  reg [15:0] cnt; // Cycles since first write
  // Count while the window is open
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      run <= 1'b0;
      cnt <= 16'h0000;
      o_expire <= 1'b0;
    end else if (i_start) begin
      run <= 1'b1;
      cnt <= 16'h0000;
      o_expire <= 1'b0;
    end else if (i_stop || !run) begin
      run <= 1'b0;
      o_expire <= 1'b0;
    end else if (cnt == GAP_CYC[15:0] - 16'h0001) begin
      // Too slow: window closes with an error
      run <= 1'b0;
      o_expire <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      o_expire <= 1'b0;
    end
  end
endmodule // wdpw_gap
`default_nettype wire

// File: logic/wdpw_top.v
// Purpose: Watchdog with password access, pre-warning and reset hold.
// Assumes: 20 MHz system clock; i_rst_n is the power-on reset.
// Notes: AXI4-Lite register slave; one write and one read at a time.
//
// What this block does
// - Counter ticks at clock over 256 or 16384
// - Normal mode reloads programmed 16-bit value
// - Time-out and pre-warning reload fixed value
// - Unserviced enabled watchdog leads to system reset
// - Error raises NMI, reset follows later
// - Drive end-of-init line, watch its changes
// - Access needs fixed plus user password
// - Two writes, gap timed, long gap invalid
// - Bad password or guard starts reset
// - Counter overflow starts reset
// - Disable keeps password and end-of-init watch
// - Second watchdog reset holds until power-on
`include "wdpw_map.vh"
`default_nettype none
module wdpw_top #(
  parameter DIV_LO = `WDPW_DIV_LO,
  parameter DIV_HI = `WDPW_DIV_HI,
  parameter GAP_CYC = `WDPW_GAP_CYC,
  parameter RST_CYC = `WDPW_RST_CYC
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  output reg o_endinit,
  output reg o_nmi,
  output reg o_sys_rst,
  output reg o_irq
);
  // Watchdog modes
  localparam MODE_NORM = 3'd0;
  localparam MODE_TOUT = 3'd1;
  localparam MODE_PREW = 3'd2;
  localparam MODE_RST = 3'd3;
  localparam MODE_HOLD = 3'd4;

  reg [2:0] mode; // Current mode
  reg [15:0] count; // Watchdog counter
  reg [15:0] reload; // Programmed reload
  reg [7:0] pw_user; // User password part
  reg dis; // Watchdog disable request
  reg psel; // High ratio select
  reg acc_open; // First write accepted
  reg acc_err; // Access error seen
  reg ovf_err; // Overflow error seen
  reg rst_seen; // One watchdog reset already issued
  reg [7:0] rst_cnt; // Reset pulse length
  reg [`WDPW_EV_N-1:0] isr; // Sticky events
  reg [`WDPW_EV_N-1:0] imr; // Event mask
  reg aw_held; // Write address captured
  reg w_held; // Write data captured
  reg [7:0] aw_addr; // Captured address
  reg [31:0] w_data; // Captured data
  reg [3:0] w_strb; // Captured strobes

  wire tick; // Counter tick
  wire gap_exp; // Gap expired

  // Write fires once both halves are present and no answer pends
  wire wr_fire = aw_held && w_held && !o_bvalid;
  wire con0_wr = wr_fire && aw_addr == `WDPW_ADDR_CON0;
  wire con1_wr = wr_fire && aw_addr == `WDPW_ADDR_CON1;
  wire imr_wr = wr_fire && aw_addr == `WDPW_ADDR_IMR;
  wire rd_fire = i_arvalid && o_arready;
  wire isr_rd = rd_fire && i_araddr == `WDPW_ADDR_ISR;

  // Password is the fixed part plus the user part
  wire pw_ok = w_data[`WDPW_C0_PWF_HI:`WDPW_C0_PWF_LO] == `WDPW_PW_FIX &&
               w_data[`WDPW_C0_PWU_HI:`WDPW_C0_PWU_LO] == pw_user;
  wire guard_ok = pw_ok && w_data[`WDPW_C0_LOCK];
  wire live = mode == MODE_NORM || mode == MODE_TOUT; // Errors counted
  wire first_bad = con0_wr && !acc_open && !pw_ok;
  wire second_bad = con0_wr && acc_open && !guard_ok;
  wire svc = con0_wr && acc_open && guard_ok;
  // Disable only stops normal-mode overflow; time-out still runs
  wire ovf = tick && count == 16'hFFFF && !(mode == MODE_NORM && dis);
  wire aerr = live && (first_bad || second_bad || (acc_open && gap_exp));
  wire oerr = live && ovf;
  wire prw_ovf = mode == MODE_PREW && tick && count == 16'hFFFF;
  wire new_endinit = w_data[`WDPW_C0_ENDINIT];
  wire end_chg = svc && new_endinit != o_endinit;

  // Counter tick divider
  wdpw_presc #(
    .DIV_LO(DIV_LO),
    .DIV_HI(DIV_HI)
  ) u_presc (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_sel_hi(psel),
    .o_tick(tick)
  );

  // Access gap limiter
  wdpw_gap #(
    .GAP_CYC(GAP_CYC)
  ) u_gap (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_start(con0_wr && !acc_open && pw_ok),
    .i_stop(con0_wr && acc_open),
    .o_expire(gap_exp)
  );

  // Write channel capture, either order
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `WDPW_RESP_OK;
    end else begin
      // Ready pulses for one cycle when a slot is free
      o_awready <= !aw_held && !o_awready && i_awvalid;
      o_wready <= !w_held && !o_wready && i_wvalid;
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        // Protected control word refuses writes after init
        if (aw_addr == `WDPW_ADDR_CON0 || aw_addr == `WDPW_ADDR_IMR)
          o_bresp <= `WDPW_RESP_OK;
        else if (aw_addr == `WDPW_ADDR_CON1 && !o_endinit)
          o_bresp <= `WDPW_RESP_OK;
        else
          o_bresp <= `WDPW_RESP_ERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `WDPW_RESP_OK;
    end else begin
      o_arready <= !o_rvalid && !o_arready && i_arvalid;
      if (rd_fire) begin
        o_rvalid <= 1'b1;
        o_rresp <= `WDPW_RESP_OK;
        if (i_araddr == `WDPW_ADDR_CON0)
          o_rdata <= {reload, pw_user, `WDPW_PW_FIX, acc_open, o_endinit};
        else if (i_araddr == `WDPW_ADDR_CON1)
          o_rdata <= {16'h0000, pw_user, 4'h0, psel, dis, 2'b00};
        else if (i_araddr == `WDPW_ADDR_SR)
          o_rdata <= {count, 9'h000, mode, rst_seen, ovf_err, acc_err, o_nmi};
        else if (i_araddr == `WDPW_ADDR_ISR)
          o_rdata <= {28'h0000000, isr};
        else if (i_araddr == `WDPW_ADDR_IMR)
          o_rdata <= {28'h0000000, imr};
        else begin
          // Unmapped address answers with an error
          o_rdata <= 32'h00000000;
          o_rresp <= `WDPW_RESP_ERR;
        end
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Control word 1 and mask, byte lane 0 and 1
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      dis <= 1'b0;
      psel <= 1'b0;
      pw_user <= `WDPW_PWU_RST;
      imr <= {`WDPW_EV_N{1'b0}};
    end else begin
      // Only writable while end-of-init is clear
      if (con1_wr && !o_endinit) begin
        if (w_strb[0]) begin
          dis <= w_data[`WDPW_C1_DIS];
          psel <= w_data[`WDPW_C1_PSEL];
        end
        if (w_strb[1])
          pw_user <= w_data[`WDPW_C1_PWU_HI:`WDPW_C1_PWU_LO];
      end
      if (imr_wr && w_strb[0])
        imr <= w_data[`WDPW_EV_N-1:0];
    end
  end

  // Sticky events; a new event wins over the read clear
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      isr <= {`WDPW_EV_N{1'b0}};
      o_irq <= 1'b0;
    end else begin
      isr <= (isr & ~{`WDPW_EV_N{isr_rd}}) |
             {prw_ovf, end_chg, oerr, aerr};
      o_irq <= |(((isr & ~{`WDPW_EV_N{isr_rd}}) |
                 {prw_ovf, end_chg, oerr, aerr}) & imr);
    end
  end

  // Watchdog core: modes, counter, access sequence
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      // Power-on: time-out mode, watchdog enabled, count loaded with the fixed reload
      mode <= MODE_TOUT;
      count <= `WDPW_FIXED_RELOAD;
      reload <= `WDPW_RELOAD_RST;
      o_endinit <= `WDPW_ENDINIT_RST;
      acc_open <= 1'b0;
      acc_err <= 1'b0;
      ovf_err <= 1'b0;
      rst_seen <= 1'b0;
      rst_cnt <= 8'h00;
      o_nmi <= 1'b0;
      o_sys_rst <= 1'b0;
    end else begin
      if (tick)
        count <= count + 16'h0001;
      // Access sequence survives a disabled watchdog
      if (con0_wr)
        acc_open <= !acc_open && pw_ok;
      else if (gap_exp)
        acc_open <= 1'b0;
      if (svc) begin
        o_endinit <= new_endinit;
        reload <= w_data[`WDPW_C0_REL_HI:`WDPW_C0_REL_LO];
      end
      case (mode)
        MODE_NORM, MODE_TOUT: begin
          if (aerr || oerr) begin
            // Warn first, reset later
            mode <= MODE_PREW;
            count <= `WDPW_FIXED_RELOAD;
            o_nmi <= 1'b1;
            acc_err <= aerr;
            ovf_err <= oerr;
          end else if (svc && new_endinit) begin
            mode <= MODE_NORM;
            count <= w_data[`WDPW_C0_REL_HI:`WDPW_C0_REL_LO];
          end else if (svc) begin
            mode <= MODE_TOUT;
            count <= `WDPW_FIXED_RELOAD;
          end else if (tick && count == 16'hFFFF) begin
            // Normal mode with watchdog disabled wraps to reload; every other wrap is an error above
            count <= reload;
          end
        end
        MODE_PREW: begin
          // Service cannot cancel the pending reset
          if (prw_ovf) begin
            mode <= MODE_RST;
            o_sys_rst <= 1'b1;
            rst_cnt <= 8'h00;
          end
        end
        MODE_RST: begin
          if (rst_seen) begin
            mode <= MODE_HOLD;
          end else if (rst_cnt == RST_CYC[7:0] - 8'h01) begin
            // First watchdog reset ends; restart as after boot
            rst_seen <= 1'b1;
            mode <= MODE_TOUT;
            count <= `WDPW_FIXED_RELOAD;
            o_endinit <= `WDPW_ENDINIT_RST;
            acc_open <= 1'b0;
            o_nmi <= 1'b0;
            o_sys_rst <= 1'b0;
          end else begin
            rst_cnt <= rst_cnt + 8'h01;
          end
        end
        MODE_HOLD: begin
          // Only power-on reset leaves this state
          o_sys_rst <= 1'b1;
        end
        default: begin
          mode <= MODE_TOUT;
        end
      endcase
    end
  end
endmodule // wdpw_top
`default_nettype wire

// File: sim/wdpw_monitor.sv
// Purpose: Port checks of the watchdog block.
// Assumes: Bound into wdpw_top; one clock, reset low.
// Notes: Latencies get one cycle of slack where the hand-over is loose.
`include "wdpw_map.vh"
`default_nettype none
module wdpw_monitor #(
  parameter RST_CYC = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_awvalid,
  input wire logic i_wvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [1:0] o_rresp,
  input wire logic [31:0] o_rdata,
  input wire logic o_endinit,
  input wire logic o_nmi,
  input wire logic o_sys_rst
);
  int hi_cnt; // Edges the reset pulse has stood high
  logic [3:0] w_hist; // Recent write-data handshakes
  // History is cleared with the block so no stale event survives reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      hi_cnt <= 0;
      w_hist <= 4'h0;
    end else begin
      hi_cnt <= o_sys_rst ? hi_cnt + 1 : 0;
      w_hist <= {w_hist[2:0], i_wvalid & o_wready};
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  AST_AW_PULSE: assert property (o_awready |=> !o_awready)
    else $error("write address ready held too long");
  AST_B_AFTER: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write response late");
  AST_B_DONE: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response repeated");
  AST_R_AFTER: assert property (i_arvalid && o_arready |-> ##[1:2] o_rvalid)
    else $error("read data late");
  AST_R_ERR_ZERO: assert property (o_rvalid && o_rresp == `WDPW_RESP_ERR |-> o_rdata == 32'h0)
    else $error("refused read returned data");
  AST_NMI_FIRST: assert property ($rose(o_sys_rst) |-> $past(o_nmi) && o_nmi)
    else $error("reset without warning");
  AST_NMI_LEAD: assert property ($rose(o_nmi) |-> !o_sys_rst [*8])
    else $error("reset too soon after warning");
  AST_RST_LEN: assert property ($fell(o_sys_rst) |-> hi_cnt == RST_CYC)
    else $error("reset pulse length wrong");
  AST_NMI_END: assert property ($fell(o_sys_rst) |-> ##[0:1] !o_nmi)
    else $error("warning outlived reset pulse");
  AST_EI_CAUSE: assert property ($changed(o_endinit) |-> (|w_hist) || o_sys_rst || $past(o_sys_rst))
    else $error("protect line moved without cause");
  AST_EI_CLEAR: assert property ($fell(o_sys_rst) |-> ##[0:1] !o_endinit)
    else $error("protect line kept after reset");
  // Main scenarios reached
  COV_NMI: cover property ($rose(o_nmi));
  COV_RST: cover property ($fell(o_sys_rst));
  COV_EI: cover property ($rose(o_endinit));
endmodule // wdpw_monitor
bind wdpw_top wdpw_monitor #(.RST_CYC(RST_CYC)) u_mon (.i_clock, .i_rst_n, .i_awvalid, .i_wvalid,
  .i_bready, .i_arvalid, .o_awready, .o_wready, .o_bvalid, .o_arready, .o_rvalid, .o_rresp,
  .o_rdata, .o_endinit, .o_nmi, .o_sys_rst);
`default_nettype wire

// File: sim/wdpw_cpu.sv
// Purpose: CPU-side bus master that services the watchdog.
// Assumes: AXI4-Lite, one write and one read at a time.
// Notes: Released payload is inverted so a stale value never looks valid.
`default_nettype none
module wdpw_cpu (
  input wire logic i_clock,
  output logic [7:0] o_awaddr = 8'h00,
  output logic o_awvalid = 1'b0,
  input wire logic i_awready,
  output logic [31:0] o_wdata = 32'h0,
  output logic [3:0] o_wstrb = 4'hF,
  output logic o_wvalid = 1'b0,
  input wire logic i_wready,
  input wire logic i_bvalid,
  output logic o_bready = 1'b0,
  output logic [7:0] o_araddr = 8'h00,
  output logic o_arvalid = 1'b0,
  input wire logic i_arready,
  input wire logic i_rvalid,
  output logic o_rready = 1'b0
);
  // One write; lag idles first so the slave also sees slow software
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int lag);
    repeat (lag) @(posedge i_clock);
    @(posedge i_clock);
    o_awaddr <= a;
    o_awvalid <= 1'b1;
    o_wdata <= d;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
    end while (!i_bvalid);
    o_bready <= 1'b0;
  endtask
  // One read; ready is held until the data is seen
  task automatic rd(input logic [7:0] a, input int lag);
    repeat (lag) @(posedge i_clock);
    @(posedge i_clock);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
      end
    end while (!i_rvalid);
    o_rready <= 1'b0;
  endtask
endmodule // wdpw_cpu
`default_nettype wire

// File: sim/test_watchdog_with_prewarning.sv
// Purpose: Self-checking bench of the watchdog block.
// Assumes: Short counts: divider 8 or 64, gap 16, reset pulse 4.
// Notes: Responses are checked by a watcher against queued notes.
`include "wdpw_map.vh"
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin miscompares++; $display("BAD %0t got %h want %h", $time, g, x); end end
module test_watchdog_with_prewarning;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [33:0] ALL = {34{1'b1}}; // Every bit
  localparam logic [33:0] MODE = 34'h3_0000_0070; // Response and mode field
  localparam logic [33:0] EVT = 34'h3_0000_000F; // Response and events
  logic i_clock = 1'b0; // System clock
  logic i_rst_n = 1'b0; // Power-on reset
  wire logic [7:0] i_awaddr, i_araddr;
  wire logic [31:0] i_wdata, o_rdata;
  wire logic [3:0] i_wstrb;
  wire logic [1:0] o_bresp, o_rresp;
  wire logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready, i_arvalid, o_arready;
  wire logic o_rvalid, i_rready, o_endinit, o_nmi, o_sys_rst, o_irq;
  int seed = 60; // Random stream start
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0; // Hang guard
  int k; // Wait bound
  logic [1:0] bq[$]; // Expected write answers
  logic [33:0] eq[$], mq[$]; // Expected reads, masks
  logic [33:0] e, m; // Watcher scratch
  logic [1:0] b; // Watcher scratch
  logic [7:0] upw; // Random user password
  logic [15:0] rl; // Random reload
  always #25 i_clock = ~i_clock;
  wdpw_top #(.DIV_LO(8), .DIV_HI(64), .GAP_CYC(16), .RST_CYC(4)) DUT (.i_clock, .i_rst_n, .i_awaddr,
    .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_endinit, .o_nmi,
    .o_sys_rst, .o_irq);
  wdpw_cpu cpu (.i_clock, .o_awaddr(i_awaddr), .o_awvalid(i_awvalid), .i_awready(o_awready),
    .o_wdata(i_wdata), .o_wstrb(i_wstrb), .o_wvalid(i_wvalid), .i_wready(o_wready), .i_bvalid(o_bvalid),
    .o_bready(i_bready), .o_araddr(i_araddr), .o_arvalid(i_arvalid), .i_arready(o_arready),
    .i_rvalid(o_rvalid), .o_rready(i_rready));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watcher: each answer is compared with the oldest note
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (i_bready && o_bvalid) begin
      b = bq.pop_front();
      `CHK(o_bresp, b)
    end
    if (i_rready && o_rvalid) begin
      e = eq.pop_front();
      m = mq.pop_front();
      `CHK({o_rresp, o_rdata} & m, e & m)
    end
    if (cyc == 8000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    cpu.wr(a, d, $random(seed) & 1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] x, input logic [33:0] mk);
    eq.push_back(x);
    mq.push_back(mk);
    cpu.rd(a, $random(seed) & 1);
  endtask
  // Two-write service: open with password, then apply with guard set
  task automatic svc(input logic [7:0] pw, input logic [15:0] r, input logic ei);
    wr(`WDPW_ADDR_CON0, {16'h0, pw, `WDPW_PW_FIX, 2'b00}, `WDPW_RESP_OK);
    wr(`WDPW_ADDR_CON0, {r, pw, `WDPW_PW_FIX, 1'b1, ei}, `WDPW_RESP_OK);
    @(negedge i_clock);
  endtask
  initial begin
    upw = 8'h01 | 8'($random(seed));
    rl = 16'hFFE0 | (16'($random(seed)) & 16'h0007);
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(`WDPW_ADDR_CON0, {26'h0, `WDPW_PW_FIX, 2'b00}, ALL);
    svc(8'h00, rl, 1'b1);
    `CHK(o_endinit, 1'b1)
    rd(`WDPW_ADDR_SR, 34'h0, MODE);
    rd(`WDPW_ADDR_CON0, {2'b00, rl, 8'h00, `WDPW_PW_FIX, 2'b01}, ALL);
    wr(`WDPW_ADDR_CON1, 32'h0000_0008, `WDPW_RESP_ERR);
    wr(`WDPW_ADDR_SR, 32'h0, `WDPW_RESP_ERR);
    rd(8'h14, {`WDPW_RESP_ERR, 32'h0}, ALL);
    wr(`WDPW_ADDR_IMR, 32'h0000_000F, `WDPW_RESP_OK);
    @(negedge i_clock);
    `CHK(o_irq, 1'b1)
    rd(`WDPW_ADDR_ISR, 34'h4, EVT);
    rd(`WDPW_ADDR_ISR, 34'h0, EVT);
    @(negedge i_clock);
    `CHK(o_irq, 1'b0)
    repeat (100) @(posedge i_clock);
    svc(8'h00, rl, 1'b1);
    repeat (150) @(posedge i_clock);
    `CHK(o_nmi, 1'b0)
    $display("done: service and registers");
    svc(8'h00, rl, 1'b0);
    wr(`WDPW_ADDR_CON1, {16'h0, upw, 8'h0C}, `WDPW_RESP_OK);
    svc(upw, 16'hFFF0, 1'b1);
    repeat (1100) @(posedge i_clock);
    `CHK(o_nmi, 1'b0)
    rd(`WDPW_ADDR_SR, 34'h0_FF00_0000, 34'h3_FF00_0070);
    wr(`WDPW_ADDR_CON0, {16'h0, ~upw, `WDPW_PW_FIX, 2'b00}, `WDPW_RESP_OK);
    @(negedge i_clock);
    `CHK(o_nmi, 1'b1)
    rd(`WDPW_ADDR_SR, 34'h20, MODE);
    for (k = 0; k < 400 && o_sys_rst !== 1'b1; k++) @(posedge i_clock);
    `CHK(o_sys_rst, 1'b1)
    repeat (8) @(posedge i_clock);
    `CHK(o_sys_rst, 1'b0)
    `CHK(o_endinit, 1'b0)
    $display("done: disable and first reset");
    for (k = 0; k < 1000 && o_sys_rst !== 1'b1; k++) @(posedge i_clock);
    rd(`WDPW_ADDR_SR, 34'h40, MODE);
    repeat (100) @(posedge i_clock);
    `CHK(o_sys_rst, 1'b1)
    i_rst_n <= 1'b0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(negedge i_clock);
    `CHK(o_sys_rst, 1'b0)
    rd(`WDPW_ADDR_CON0, {26'h0, `WDPW_PW_FIX, 2'b00}, ALL);
    svc(8'h00, 16'h0000, 1'b1);
    $display("done: hold and power-on");
    wr(`WDPW_ADDR_CON0, {16'h0, 8'h00, `WDPW_PW_FIX, 2'b00}, `WDPW_RESP_OK);
    repeat (20) @(posedge i_clock);
    wr(`WDPW_ADDR_CON0, {24'h0, `WDPW_PW_FIX, 2'b11}, `WDPW_RESP_OK);
    @(negedge i_clock);
    `CHK(o_nmi, 1'b1)
    $display("done: access gap");
    report_and_stop();
  end
endmodule // test_watchdog_with_prewarning
`default_nettype wire
